// ===== core/frame_stats_pkg.sv
package frame_stats_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CNT_W        = 32;
    localparam int NUM_CNT      = 15;
    localparam int IDX_W        = 4;
    localparam int LEN_W        = 16;
    localparam int CHAN_W       = 3;

    // ------------------------------------------------------------
    // Frame, counter and clear constants
    // ------------------------------------------------------------
    localparam logic [LEN_W-1:0] MIN_FRAME_LEN  = 16'h0040;
    localparam logic [15:0]      PAUSE_TYPE     = 16'h8808;
    localparam logic [15:0]      PAUSE_OPCODE   = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_THRESHOLD  = 32'h8000_0000;
    localparam logic [CNT_W-1:0] CNT_ZERO       = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE        = 32'h0000_0001;
    localparam int               CLEAR_DELAY    = 38;

    // ------------------------------------------------------------
    // Counter indices; byte address = index * 4
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_RX_MCAST   = 4'h0;
    localparam logic [IDX_W-1:0] IDX_RX_PAUSE   = 4'h1;
    localparam logic [IDX_W-1:0] IDX_RX_FCS     = 4'h2;
    localparam logic [IDX_W-1:0] IDX_RX_ALIGN   = 4'h3;
    localparam logic [IDX_W-1:0] IDX_RX_LONG    = 4'h4;
    localparam logic [IDX_W-1:0] IDX_RX_LBAD    = 4'h5;
    localparam logic [IDX_W-1:0] IDX_RX_SHORT   = 4'h6;
    localparam logic [IDX_W-1:0] IDX_RX_SBAD    = 4'h7;
    localparam logic [IDX_W-1:0] IDX_RX_FILT    = 4'h8;
    localparam logic [IDX_W-1:0] IDX_RX_QOS     = 4'h9;
    localparam logic [IDX_W-1:0] IDX_RX_BYTES   = 4'ha;
    localparam logic [IDX_W-1:0] IDX_TX_GOOD    = 4'hb;
    localparam logic [IDX_W-1:0] IDX_TX_BCAST   = 4'hc;
    localparam logic [IDX_W-1:0] IDX_TX_MCAST   = 4'hd;
    localparam logic [IDX_W-1:0] IDX_TX_PAUSE   = 4'he;
    localparam logic [IDX_W-1:0] IDX_RX_OVERRUN = 4'hf;
    localparam logic [11:0]      ADDR_CTRL      = 12'h040;
    localparam logic [11:0]      ADDR_STATUS    = 12'h044;
    localparam int               ADDR_LSB       = 2;

    // Control register bits
    localparam int CTRL_DECR_BIT  = 0;
    localparam int CTRL_TXFLOW_BIT = 1;
    localparam int CTRL_QOS_BIT   = 2;
    localparam int CTRL_IRQEN_BIT = 3;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Frame reports
    // ------------------------------------------------------------
    typedef struct packed {
        logic             done;
        logic [LEN_W-1:0] length;
        logic             addr_match;
        logic             promisc;
        logic             is_control;
        logic             dest_mcast;
        logic             dest_bcast;
        logic             odd_nibbles;
        logic             fcs_fail;
        logic             rx_error_seen;
        logic [15:0]      len_type;
        logic [15:0]      opcode;
        logic             flow_collision;
        logic             overrun;
        logic [CHAN_W-1:0] channel;
        logic [15:0]      chan_threshold;
        logic [15:0]      chan_free;
    } rx_report_t;

    typedef struct packed {
        logic done;
        logic dest_mcast;
        logic dest_bcast;
        logic late_coll;
        logic excess_coll;
        logic carrier_lost;
        logic underrun;
        logic hw_pause;
    } tx_report_t;

endpackage : frame_stats_pkg

// ===== core/stat_counter.sv
`timescale 1ns/100ps
`default_nettype none
module stat_counter #(
    parameter int W = 32
) (
    // Clock and clear
    input  wire logic         aclk,
    input  wire logic         clear,
    // Frame event
    input  wire logic [W-1:0] inc,
    // Host write
    input  wire logic         wr,
    input  wire logic         decr,
    input  wire logic [W-1:0] wdata,
    // Value
    output logic      [W-1:0] count
);
    logic [W-1:0] base;
    logic [W-1:0] count_next;

    always_comb begin
        if (!wr) begin
            base = count;
        end else if (!decr) begin
            base = wdata;
        end else if (wdata > count) begin
            base = '0;
        end else begin
            base = count - wdata;
        end
        count_next = base + inc;
    end

    always_ff @(posedge aclk) begin
        if (clear) begin
            count <= '0;
        end else begin
            count <= count_next;
        end
    end
endmodule : stat_counter
`default_nettype wire

// ===== core/ethernet_frame_statistics.sv
`timescale 1ns/100ps
`default_nettype none
module ethernet_frame_statistics
    import frame_stats_pkg::*;
#(
    parameter int MAX_LEN_DEFAULT = 1518
) (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // Frame engine reports
    input  wire frame_stats_pkg::rx_report_t rx_rep,
    input  wire frame_stats_pkg::tx_report_t tx_rep,
    // Configuration
    input  wire logic [frame_stats_pkg::LEN_W-1:0] max_rx_frame_length,
    // AXI4-Lite write address
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0]              s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Status outputs
    output logic                          stats_irq_pending,
    output logic                          stats_ready
);
    import frame_stats_pkg::*;

    // ------------------------------------------------------------
    // Clear sequencer
    // ------------------------------------------------------------
    localparam int NCNT = NUM_CNT + 1;

    logic [5:0]  clr_cnt_reg;
    logic        clearing;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_cnt_reg <= 6'h00;
        end else if (clr_cnt_reg != 6'(CLEAR_DELAY)) begin
            clr_cnt_reg <= clr_cnt_reg + 6'h01;
        end
    end

    assign clearing    = !aresetn || (clr_cnt_reg != 6'(CLEAR_DELAY));
    assign stats_ready = !clearing;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [3:0]  mac_control_reg;
    logic        decr_mode;
    logic        tx_flow_ctrl_enable;
    logic        rx_qos_enable;
    logic        irq_enable;

    assign decr_mode           = mac_control_reg[CTRL_DECR_BIT];
    assign tx_flow_ctrl_enable = mac_control_reg[CTRL_TXFLOW_BIT];
    assign rx_qos_enable       = mac_control_reg[CTRL_QOS_BIT];
    assign irq_enable          = mac_control_reg[CTRL_IRQEN_BIT];

    // ------------------------------------------------------------
    // Receive and transmit classification
    // ------------------------------------------------------------
    logic [LEN_W-1:0] max_len;
    logic rx_done, accepted, ctl, fcs_err, align_err, code_err, any_err;
    logic len_legal, len_long, len_short, rx_bad_alignfree;
    logic [NCNT-1:0] hit;
    logic [CNT_W-1:0] byte_inc;

    assign max_len   = (max_rx_frame_length == '0) ?
                       LEN_W'(MAX_LEN_DEFAULT) : max_rx_frame_length;
    assign rx_done   = rx_rep.done;
    assign accepted  = rx_rep.addr_match || rx_rep.promisc;
    assign ctl       = rx_rep.is_control;
    assign fcs_err   = rx_rep.fcs_fail && !rx_rep.odd_nibbles;
    assign align_err = rx_rep.fcs_fail && rx_rep.odd_nibbles;
    assign code_err  = rx_rep.rx_error_seen;
    assign any_err   = fcs_err || align_err || code_err;
    assign len_legal = (rx_rep.length >= MIN_FRAME_LEN) &&
                       (rx_rep.length <= max_len);
    assign len_long  = rx_rep.length > max_len;
    assign len_short = rx_rep.length < MIN_FRAME_LEN;
    assign rx_bad_alignfree = !align_err && !code_err;

    always_comb begin
        hit = '0;
        hit[IDX_RX_MCAST] = rx_done && accepted && rx_rep.dest_mcast &&
                            !rx_rep.dest_bcast && len_legal &&
                            !any_err;
        hit[IDX_RX_PAUSE] = rx_done && ctl &&
                            rx_rep.len_type == PAUSE_TYPE &&
                            rx_rep.opcode == PAUSE_OPCODE &&
                            len_legal && !any_err &&
                            tx_flow_ctrl_enable;
        hit[IDX_RX_FCS]   = rx_done && accepted && len_legal &&
                            rx_bad_alignfree && fcs_err;
        hit[IDX_RX_ALIGN] = rx_done && accepted && len_legal &&
                            (align_err || code_err);
        hit[IDX_RX_LONG]  = rx_done && accepted && len_long &&
                            !any_err;
        hit[IDX_RX_LBAD]  = rx_done && accepted && len_long &&
                            any_err;
        hit[IDX_RX_SHORT] = rx_done && accepted && !ctl && len_short &&
                            !any_err;
        hit[IDX_RX_SBAD]  = rx_done && !ctl && len_short && any_err &&
                            !rx_rep.flow_collision;
        hit[IDX_RX_FILT]  = rx_done && !ctl && !accepted &&
                            !any_err;
        hit[IDX_RX_QOS]   = rx_done && accepted && len_legal && !any_err &&
                            rx_qos_enable &&
                            (rx_rep.chan_threshold >=
                             rx_rep.chan_free);
        hit[IDX_RX_OVERRUN] = rx_done && rx_rep.overrun;
        // Transmit side, then the receive byte count
        hit[IDX_TX_GOOD]  = tx_rep.done && !tx_rep.late_coll &&
                            !tx_rep.excess_coll && !tx_rep.carrier_lost &&
                            !tx_rep.underrun;
        hit[IDX_TX_BCAST] = hit[IDX_TX_GOOD] && tx_rep.dest_bcast;
        hit[IDX_TX_MCAST] = hit[IDX_TX_GOOD] && tx_rep.dest_mcast &&
                            !tx_rep.dest_bcast;
        hit[IDX_TX_PAUSE] = tx_rep.done && tx_rep.hw_pause;
        hit[IDX_RX_BYTES] = rx_done && accepted && len_legal &&
                            !any_err;
    end

    assign byte_inc = CNT_W'(rx_rep.length);

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic [11:0] aw_addr_reg;
    logic        aw_have_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        w_have_reg;
    logic        wr_fire;
    logic        wr_full;
    logic        wr_cnt_hit;
    logic [IDX_W-1:0] wr_idx;

    assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_reg && !s_axi_bvalid;
    assign wr_fire       = aw_have_reg && w_have_reg;
    assign wr_full       = w_strb_reg == 4'hf;
    assign wr_idx        = aw_addr_reg[ADDR_LSB +: IDX_W];
    assign wr_cnt_hit    = wr_fire && wr_full && !clearing &&
                           aw_addr_reg < ADDR_CTRL;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_full && (aw_addr_reg < ADDR_CTRL ||
                            aw_addr_reg == ADDR_CTRL)) ?
                            RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mac_control_reg <= 4'h0;
        end else if (wr_fire && wr_full && aw_addr_reg == ADDR_CTRL) begin
            mac_control_reg <= w_data_reg[3:0];
        end
    end

    // ------------------------------------------------------------
    // Counter bank
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt [NCNT];
    logic [NCNT-1:0]  over;

    genvar gi;
    generate
        for (gi = 0; gi < NCNT; gi++) begin : g_cnt
            stat_counter #(.W(CNT_W)) u_cnt (
                .aclk  (aclk),
                .clear (clearing),
                .inc   ((gi == int'(IDX_RX_BYTES)) ?
                        (hit[gi] ? byte_inc : CNT_ZERO) :
                        (hit[gi] ? CNT_ONE : CNT_ZERO)),
                .wr    (wr_cnt_hit && wr_idx == IDX_W'(gi)),
                .decr  (decr_mode),
                .wdata (w_data_reg),
                .count (cnt[gi])
            );
            assign over[gi] = cnt[gi] >= CNT_THRESHOLD;
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stats_irq_pending <= 1'b0;
        end else begin
            stats_irq_pending <= irq_enable && (|over);
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr < ADDR_CTRL) begin
                s_axi_rdata <= cnt[s_axi_araddr[ADDR_LSB +: IDX_W]];
            end else if (s_axi_araddr == ADDR_CTRL) begin
                s_axi_rdata <= {28'h0000000, mac_control_reg};
            end else if (s_axi_araddr == ADDR_STATUS) begin
                s_axi_rdata <= {30'h00000000, stats_ready,
                                stats_irq_pending};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ethernet_frame_statistics
`default_nettype wire

// ===== tb/frame_stats_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Bus and clear checks
// ------------------------------------------------------------
module frame_stats_sva
    import frame_stats_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [11:0] s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Status
    input wire logic        stats_ready
);
    logic [7:0]  clr_cnt_reg;
    logic        strb_bad_reg;
    logic [11:0] aw_addr_reg;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clr_cnt_reg <= 8'h00;
        end else if (clr_cnt_reg < 8'h3c) begin
            clr_cnt_reg <= clr_cnt_reg + 8'h01;
        end
    end
    always_ff @(posedge aclk) begin
        if (s_axi_wvalid && s_axi_wready) begin
            strb_bad_reg <= (s_axi_wstrb != 4'hf);
        end
    end
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg <= s_axi_awaddr;
        end
    end
    chk_clear_hold: assert property (
        clr_cnt_reg < 8'h26 |-> !stats_ready)
        else $error("counters ready too early");
    chk_clear_done: assert property (
        clr_cnt_reg > 8'h25 |-> stats_ready)
        else $error("counters not ready in time");
    chk_ready_stays: assert property (
        stats_ready |=> stats_ready)
        else $error("ready dropped");
    chk_write_resp: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    chk_bresp_code: assert property (
        $rose(s_axi_bvalid) && aw_addr_reg < 12'h044
        |-> s_axi_bresp == (strb_bad_reg ? RESP_SLVERR : RESP_OKAY))
        else $error("wrong write response");
    chk_read_resp: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_unmapped_rd: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h047
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_w_refuse: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    chk_r_refuse: assert property (
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
endmodule : frame_stats_sva

bind ethernet_frame_statistics frame_stats_sva frame_stats_sva_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .stats_ready
);
`default_nettype wire

// ===== tb/mac_frame_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Frame engine reports, one-cycle pulses
// ------------------------------------------------------------
module mac_frame_model
    import frame_stats_pkg::*;
(
    // Clock
    input  wire logic                      aclk,
    // Reports
    output var frame_stats_pkg::rx_report_t rx_rep,
    output var frame_stats_pkg::tx_report_t tx_rep
);
    initial begin
        rx_rep = '0;
        tx_rep = '0;
    end
    // Stale fields are inverted once the pulse is over
    task automatic send_rx(input rx_report_t r);
        @(posedge aclk);
        rx_rep <= r;
        @(posedge aclk);
        rx_rep <= ~r;
    endtask : send_rx
    task automatic send_tx(input tx_report_t t);
        @(posedge aclk);
        tx_rep <= t;
        @(posedge aclk);
        tx_rep <= ~t;
    endtask : send_tx
endmodule : mac_frame_model
`default_nettype wire

// ===== tb/ethernet_frame_statistics_test.sv
`timescale 1ns/100ps
`default_nettype none
module ethernet_frame_statistics_test;
    import frame_stats_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [10:0] MT = 11'h001, PR = 11'h002, CT = 11'h004,
        MC = 11'h008, BC = 11'h010, OD = 11'h020, FC = 11'h040,
        ER = 11'h080, CO = 11'h100, OV = 11'h200, QS = 11'h400;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    rx_report_t rx_rep;
    tx_report_t tx_rep;
    logic [15:0] max_rx_frame_length = 16'h0064;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, stats_irq_pending, stats_ready;
    logic [31:0] exp_cnt [16];
    logic [31:0] d;
    int errors = 0;
    int comparisons = 0;
    always #2 aclk = ~aclk;
    ethernet_frame_statistics ethernet_frame_statistics_i (.aclk,
        .aresetn, .rx_rep, .tx_rep, .max_rx_frame_length, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .stats_irq_pending, .stats_ready);
    mac_frame_model mac_frame_model_i (.aclk, .rx_rep, .tx_rep);
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            errors++;
            $display("ERROR %0t: got %h want %h", $time, got, want);
        end
    endtask : cmp
    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [1:0] resp);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic chk_all();
        logic [31:0] v;
        logic [1:0] s;
        for (int i = 0; i < 16; i++) begin
            rd(12'(i * 4), v, s);
            cmp(v, exp_cnt[i]);
        end
    endtask : chk_all
    task automatic upd(input logic [15:0] m, input logic [15:0] len);
        for (int i = 0; i < 16; i++) begin
            if (m[i]) exp_cnt[i] += (i == 10) ? {16'h0, len} : 32'h1;
        end
    endtask : upd
    task automatic rxf(input logic [15:0] len, input logic [10:0] f,
                       input logic [15:0] m);
        rx_report_t rp;
        rp = '0;
        rp.done = 1'b1;
        rp.length = len;
        {rp.overrun, rp.flow_collision, rp.rx_error_seen, rp.fcs_fail,
         rp.odd_nibbles, rp.dest_bcast, rp.dest_mcast, rp.is_control,
         rp.promisc, rp.addr_match} = f[9:0];
        rp.len_type = f[2] ? PAUSE_TYPE : 16'h0800;
        rp.opcode = PAUSE_OPCODE;
        rp.chan_threshold = 16'h0004;
        rp.chan_free = f[10] ? 16'h0004 : 16'h0005;
        mac_frame_model_i.send_rx(rp);
        upd(m, len);
        chk_all();
    endtask : rxf
    task automatic txf(input logic [6:0] f, input logic [15:0] m);
        mac_frame_model_i.send_tx({1'b1, f});
        upd(m, 16'h0);
        chk_all();
    endtask : txf
    task automatic wchk(input int i, input logic [31:0] v,
                        input logic [31:0] want);
        logic [31:0] g;
        logic [1:0] s;
        wr(12'(i * 4), v, 4'hf, s);
        exp_cnt[i] = want;
        rd(12'(i * 4), g, s);
        cmp(g, want);
    endtask : wchk
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge aclk);
        errors++;
        test_done();
    end
    initial begin
        foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        wr(12'h000, 32'h5, 4'hf, r);
        for (int n = 0; n < 100 && stats_ready !== 1'b1; n++) @(posedge aclk);
        cmp({31'h0, stats_ready}, 32'h1);
        chk_all();
        $display("test reset done");
        wr(ADDR_CTRL, 32'h6, 4'hf, r);
        rxf(16'd64, MT | MC, 16'h0401);
        rxf(16'd100, MT | MC | BC, 16'h0400);
        rxf(16'd64, PR | MC, 16'h0401);
        rxf(16'd64, MT | CT, 16'h0402);
        rxf(16'd80, MT | FC, 16'h0004);
        rxf(16'd80, MT | OD | FC, 16'h0008);
        rxf(16'd80, MT | ER, 16'h0008);
        rxf(16'd101, MT, 16'h0010);
        rxf(16'd101, PR | FC, 16'h0020);
        rxf(16'd63, MT, 16'h0040);
        rxf(16'd63, FC, 16'h0080);
        rxf(16'd63, FC | CO, 16'h0000);
        rxf(16'd80, 11'h000, 16'h0100);
        rxf(16'd80, OV, 16'h8100);
        rxf(16'd80, MT | QS, 16'h0600);
        max_rx_frame_length <= 16'h0000;
        rxf(16'd101, MT, 16'h0400);
        max_rx_frame_length <= 16'h0064;
        $display("test receive done");
        txf(7'h00, 16'h0800);
        txf(7'h60, 16'h1800);
        txf(7'h40, 16'h2800);
        for (int k = 1; k < 5; k++) txf(7'h40 | (7'h01 << k), 16'h0);
        txf(7'h41, 16'h6800);
        txf(7'h45, 16'h4000);
        $display("test transmit done");
        wchk(0, 32'h0000_000a, 32'h0000_000a);
        wr(12'h000, 32'h5, 4'h3, r);
        cmp({30'h0, r}, {30'h0, RESP_SLVERR});
        rd(12'h080, d, r);
        cmp({d[31:2], r}, {30'h0, RESP_SLVERR});
        wr(ADDR_CTRL, 32'h7, 4'hf, r);
        wchk(0, 32'h0000_0003, 32'h0000_0007);
        wchk(0, 32'hffff_ffff, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h6, 4'hf, r);
        wchk(11, 32'hffff_ffff, 32'hffff_ffff);
        txf(7'h00, 16'h0800);
        $display("test host done");
        wchk(1, 32'h8000_0000, 32'h8000_0000);
        repeat (3) @(posedge aclk);
        cmp({31'h0, stats_irq_pending}, 32'h0);
        wr(ADDR_CTRL, 32'he, 4'hf, r);
        repeat (3) @(posedge aclk);
        cmp({31'h0, stats_irq_pending}, 32'h1);
        rd(ADDR_STATUS, d, r);
        cmp(d, 32'h0000_0003);
        rd(ADDR_CTRL, d, r);
        cmp(d, 32'h0000_000e);
        wr(ADDR_CTRL, 32'hf, 4'hf, r);
        wchk(1, 32'h0000_0001, 32'h7fff_ffff);
        repeat (3) @(posedge aclk);
        cmp({31'h0, stats_irq_pending}, 32'h0);
        $display("test interrupt done");
        wr(ADDR_CTRL, 32'he, 4'hf, r);
        exp_cnt[0] = 32'h0000_0005;
        fork
            wr(12'h000, 32'h5, 4'hf, r);
            begin
                @(posedge aclk);
                rxf(16'd64, MT | MC, 16'h0401);
            end
        join
        $display("test collision done");
        test_done();
    end
endmodule : ethernet_frame_statistics_test
`default_nettype wire
